/* rtl/wslc_defs.vh */
// register offsets, field positions, reset values and timing for the wiper source block
`ifndef WSLC_DEFS_VH
`define WSLC_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define WSLC_ADDR_INITIAL_VALUE 8'h00
`define WSLC_ADDR_STORAGE_CONTROL 8'h02
`define WSLC_ADDR_WIPER_SOURCE_CONTROL 8'h03
`define WSLC_ADDR_TABLE_SLOT_POINTER 8'h08
`define WSLC_ADDR_WIPER_POSITION 8'h09
`define WSLC_ADDR_MANUAL_OVERRIDE_CONTROL 8'h0A
`define WSLC_ADDR_TEMPERATURE_RESULT 8'h0C
`define WSLC_ADDR_SUPPLY_VOLTAGE_RESULT 8'h0E
`define WSLC_ADDR_TABLE_FIRST 8'h80
`define WSLC_ADDR_TABLE_LAST 8'hC7
// ----------------------------------------
// field positions
// ----------------------------------------
`define WSLC_BIT_AUTO_UPDATE 0
`define WSLC_BIT_SUM_SELECT 1
`define WSLC_BIT_POINTER_MANUAL 1
`define WSLC_BIT_WIPER_MANUAL 2
`define WSLC_BIT_SHADOW_SELECT 7
// ----------------------------------------
// reset values and table limits
// ----------------------------------------
`define WSLC_RST_WIPER_SOURCE_CONTROL 8'h03
`define WSLC_RST_ZERO 8'h00
`define WSLC_TEMP_LOW 8'hD8
`define WSLC_TEMP_HIGH 8'h65
`define WSLC_WIPER_MAX 7'h7F
// ----------------------------------------
// timing
// ----------------------------------------
`define WSLC_CLK_HZ 25000000
`define WSLC_FRAME_US 10000
`define WSLC_FRAME_CYCLES ((`WSLC_FRAME_US * (`WSLC_CLK_HZ / 1000)) / 1000)
`endif

/* rtl/wslc_table_mem.v */
// 72-entry temperature table memory with registered read data
`timescale 1ns/10ps
module wslc_table_mem #(
    parameter DEPTH = 72,
    parameter AW = 7
) (
    // clock
    input wire clk_in,
    // host write port
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [7:0] wr_data_in,
    // read ports
    input wire [AW-1:0] rd_addr_in,
    output reg [7:0] rd_data_out,
    input wire [AW-1:0] lk_addr_in,
    output reg [7:0] lk_data_out
);
    reg [7:0] mem_reg [0:DEPTH-1];
    integer i;

    // contents stand for the nonvolatile array; they start at zero
    initial begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem_reg[i] = 8'h00;
        end
        rd_data_out = 8'h00;
        lk_data_out = 8'h00;
    end

    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_reg[rd_addr_in];
        lk_data_out <= mem_reg[lk_addr_in];
    end
endmodule

/* rtl/wslc_slot_map.v */
// maps a temperature reading to a table slot, with one degree of hysteresis
`timescale 1ns/10ps
`include "wslc_defs.vh"
module wslc_slot_map (
    // reading and current slot
    input wire [7:0] temp_in,
    input wire [7:0] cur_slot_in,
    // chosen slot
    output wire [7:0] slot_out
);
    // ----------------------------------------
    // plain two-degree window
    // ----------------------------------------
    function [7:0] raw_slot;
        input [7:0] t;
        reg [8:0] off;
        begin
            off = 9'h000;
            if ($signed(t) <= $signed(`WSLC_TEMP_LOW)) begin
                raw_slot = `WSLC_ADDR_TABLE_FIRST;
            end else if ($signed(t) >= $signed(`WSLC_TEMP_HIGH)) begin
                raw_slot = `WSLC_ADDR_TABLE_LAST;
            end else begin
                // -39 maps to slot 1; offset (t + 40 + 1) / 2
                off = {t[7], t} + 9'h029;
                raw_slot = `WSLC_ADDR_TABLE_FIRST + {1'b0, off[7:1]};
            end
        end
    endfunction

    wire [7:0] here = raw_slot(temp_in);
    wire [7:0] up1 = raw_slot(temp_in + 8'h01);
    wire [7:0] dn1 = raw_slot(temp_in - 8'h01);
    wire cur_valid = (cur_slot_in >= `WSLC_ADDR_TABLE_FIRST) &&
        (cur_slot_in <= `WSLC_ADDR_TABLE_LAST);

    // hold slot within a degree
    // keep the present slot while the reading sits a degree inside its neighbour
    assign slot_out = (cur_valid && here != cur_slot_in &&
        (up1 == cur_slot_in || dn1 == cur_slot_in)) ? cur_slot_in : here;
endmodule

/* rtl/wslc_top.v */
// wiper source selection, temperature table control and result registers
// Behaviour
// - sum select works only with auto update
// - sum select 0 loads table or initial
// - sum select 1 loads table plus initial
// - auto update 0 loads initial, halts results
// - auto update 1: host or table drives
// - pointer picks one of 72 slots
// - power-up restores source control from copy
// - auto update 0 disables converter updates
// - pointer holds slot index, always readable
// - pointer writes only when pointer manual
// - pointer reads zero until first frame
// - wiper writes only when wiper manual
// - wiper is unsigned seven bits
// - wiper refreshed per frame, else holds initial
// - wiper manual bit only in table modes
// - pointer manual bit only in table modes
// - temperature result signed, per frame, gated
// - supply result per frame, gated
// - table entries unsigned or signed seven bit
// - two degrees per slot, clamped ends
// - one degree slot hysteresis
// - shadow select spares nonvolatile copy
`timescale 1ns/10ps
`include "wslc_defs.vh"
module wslc_top #(
    parameter FRAME_CYCLES = `WSLC_FRAME_CYCLES,
    parameter TABLE_DEPTH = 72
) (
    // clock and reset
    input wire mclk_in,
    input wire resetn_in,
    // register access from the serial transport
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    // converter results
    input wire [7:0] adc_temp_in,
    input wire [7:0] adc_supply_in,
    output wire adc_enable_out,
    output reg frame_tick_out,
    // resistor drive
    output reg [6:0] wiper_out
);
    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    // reset drops at once but leaves two edges later, so no register
    // sees a release that lands close to a clock edge
    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rst_n = rst_sync_reg;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] initial_value_reg;
    reg [7:0] storage_control_reg;
    reg [7:0] src_ctrl_nv_reg;
    reg [7:0] wiper_source_control_reg;
    reg [7:0] table_slot_pointer_reg;
    reg [6:0] wiper_position_reg;
    reg [7:0] manual_override_control_reg;
    reg [7:0] temperature_result_reg;
    reg [7:0] supply_voltage_result_reg;
    reg [31:0] frame_cnt_reg;
    reg first_frame_done_reg;
    reg restore_pending_reg;

    wire auto_update = wiper_source_control_reg[`WSLC_BIT_AUTO_UPDATE];
    wire sum_select = auto_update & wiper_source_control_reg[`WSLC_BIT_SUM_SELECT];
    wire wiper_manual = auto_update &
        manual_override_control_reg[`WSLC_BIT_WIPER_MANUAL];
    wire pointer_manual = auto_update &
        manual_override_control_reg[`WSLC_BIT_POINTER_MANUAL];
    wire shadow_select = storage_control_reg[`WSLC_BIT_SHADOW_SELECT];

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    // every write enable except the table window's comes from this one compare
    function wr_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            wr_hit = strobe && addr == target;
        end
    endfunction

    wire wr_iv = wr_hit(reg_wr_in, reg_addr_in, `WSLC_ADDR_INITIAL_VALUE);
    wire wr_sc = wr_hit(reg_wr_in, reg_addr_in, `WSLC_ADDR_STORAGE_CONTROL);
    wire wr_src = wr_hit(reg_wr_in, reg_addr_in, `WSLC_ADDR_WIPER_SOURCE_CONTROL);
    wire wr_ptr = wr_hit(reg_wr_in, reg_addr_in, `WSLC_ADDR_TABLE_SLOT_POINTER);
    wire wr_wip = wr_hit(reg_wr_in, reg_addr_in, `WSLC_ADDR_WIPER_POSITION);
    wire wr_ovr = wr_hit(reg_wr_in, reg_addr_in, `WSLC_ADDR_MANUAL_OVERRIDE_CONTROL);
    // the whole table window shares one write enable
    wire in_table = reg_addr_in >= `WSLC_ADDR_TABLE_FIRST &&
        reg_addr_in <= `WSLC_ADDR_TABLE_LAST;
    wire wr_tab = reg_wr_in && in_table;

    // ----------------------------------------
    // frame timer
    // ----------------------------------------
    // the timer runs with auto update off too; the result latches and the pointer update stop
    wire frame_end = frame_cnt_reg == FRAME_CYCLES - 1;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt_reg <= 32'h00000000;
            frame_tick_out <= 1'b0;
        end else begin
            frame_cnt_reg <= frame_end ? 32'h00000000 : frame_cnt_reg + 32'h00000001;
            frame_tick_out <= frame_end;
        end
    end

    assign adc_enable_out = auto_update;

    // ----------------------------------------
    // table memory and slot mapping
    // ----------------------------------------
    wire [7:0] table_output_value;
    wire [7:0] mapped_slot;
    // pointer selects table slot
    // the lookup byte lags the pointer by a cycle; the wiper takes it at the next tick
    wire [7:0] ptr_off = table_slot_pointer_reg - `WSLC_ADDR_TABLE_FIRST;
    wire [7:0] rd_off = reg_addr_in - `WSLC_ADDR_TABLE_FIRST;

    // table bytes are not returned on the read bus, so that port is left open
    wslc_table_mem #(
        .DEPTH(TABLE_DEPTH),
        .AW(7)
    ) u_mem (
        .clk_in(mclk_in),
        .wr_en_in(wr_tab),
        .wr_addr_in(rd_off[6:0]),
        .wr_data_in(reg_wdata_in),
        .rd_addr_in(rd_off[6:0]),
        .rd_data_out(),
        .lk_addr_in(ptr_off[6:0]),
        .lk_data_out(table_output_value)
    );

    wslc_slot_map u_map (
        .temp_in(temperature_result_reg),
        .cur_slot_in(table_slot_pointer_reg),
        .slot_out(mapped_slot)
    );

    // ----------------------------------------
    // wiper source selection
    // ----------------------------------------
    // entry sign by sum select
    function [6:0] add_clamp;
        input [7:0] base;
        input [7:0] entry;
        reg [8:0] s;
        begin
            // entry is signed seven bits: bit 6 carries the sign
            s = {1'b0, base} + {entry[6], entry[6], entry[6:0]};
            if (s[8]) begin
                add_clamp = 7'h00;
            end else if (s[7]) begin
                add_clamp = `WSLC_WIPER_MAX;
            end else begin
                add_clamp = s[6:0];
            end
        end
    endfunction

    reg [6:0] table_wiper;
    always @* begin
        if (sum_select) begin
            table_wiper = add_clamp({1'b0, initial_value_reg[6:0]}, table_output_value);
        end else begin
            // direct table value
            // unsigned entries above 127 clamp to the top tap
            table_wiper = table_output_value[7] ? `WSLC_WIPER_MAX : table_output_value[6:0];
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            storage_control_reg <= `WSLC_RST_ZERO;
            wiper_source_control_reg <= `WSLC_RST_WIPER_SOURCE_CONTROL;
            manual_override_control_reg <= `WSLC_RST_ZERO;
            restore_pending_reg <= 1'b1;
        end else begin
            restore_pending_reg <= 1'b0;
            // a source control write in the reload cycle is lost, so the host waits one more edge
            if (restore_pending_reg) begin
                wiper_source_control_reg <= src_ctrl_nv_reg;
            end else if (wr_src) begin
                wiper_source_control_reg <= {6'h00, reg_wdata_in[1:0]};
            end
            if (wr_sc) begin
                storage_control_reg <= {reg_wdata_in[7], 7'h00};
            end
            if (wr_ovr) begin
                manual_override_control_reg <= {5'h00, reg_wdata_in[2:1], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // nonvolatile copies
    // ----------------------------------------
    // these bytes stand for stored cells, so reset leaves them alone; a reset in
    // mid-run must bring back what the host last committed, not the factory value
    initial begin
        initial_value_reg = `WSLC_RST_ZERO;
        src_ctrl_nv_reg = `WSLC_RST_WIPER_SOURCE_CONTROL;
    end

    always @(posedge mclk_in) begin
        if (rst_n && !restore_pending_reg && wr_src && !shadow_select) begin
            src_ctrl_nv_reg <= {6'h00, reg_wdata_in[1:0]};
        end
    end

    // with shadow select set an address zero write moves only the wiper
    always @(posedge mclk_in) begin
        if (rst_n && wr_iv && !shadow_select) begin
            initial_value_reg <= reg_wdata_in;
        end
    end

    // ----------------------------------------
    // results, pointer and wiper
    // ----------------------------------------
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            temperature_result_reg <= `WSLC_RST_ZERO;
            supply_voltage_result_reg <= `WSLC_RST_ZERO;
            table_slot_pointer_reg <= `WSLC_RST_ZERO;
            wiper_position_reg <= 7'h00;
            first_frame_done_reg <= 1'b0;
        end else begin
            if (frame_end && auto_update) begin
                temperature_result_reg <= adc_temp_in;
                supply_voltage_result_reg <= adc_supply_in;
            end
            // the first lookup after release reads a stale slot, so the wiper waits a frame
            if (frame_tick_out && auto_update) begin
                first_frame_done_reg <= 1'b1;
            end
            // a manual pointer write wins over the tick in the same cycle
            // pointer write gate
            if (wr_ptr && pointer_manual) begin
                table_slot_pointer_reg <= reg_wdata_in;
            end else if (frame_tick_out && auto_update && !pointer_manual) begin
                table_slot_pointer_reg <= mapped_slot;
            end
            if (restore_pending_reg) begin
                // the source byte still holds its reset value in this cycle, so the
                // stored copy decides whether the initial value is loaded
                if (!src_ctrl_nv_reg[`WSLC_BIT_AUTO_UPDATE]) begin
                    wiper_position_reg <= initial_value_reg[6:0];
                end
            end else if (!auto_update) begin
                if (wr_iv) begin
                    wiper_position_reg <= reg_wdata_in[6:0];
                end
            end else if (wr_iv) begin
                wiper_position_reg <= reg_wdata_in[6:0];
            end else if (wiper_manual) begin
                if (wr_wip) begin
                    wiper_position_reg <= reg_wdata_in[6:0];
                end
            end else if (frame_tick_out && first_frame_done_reg) begin
                wiper_position_reg <= table_wiper;
            end
        end
    end

    // the drive lags the register by a cycle so the resistor sees one settled code
    // seven bit wiper drive
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            wiper_out <= 7'h00;
        end else begin
            wiper_out <= wiper_position_reg;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
        end else begin
            case (reg_addr_in)
                `WSLC_ADDR_INITIAL_VALUE: reg_rdata_out <= shadow_select ?
                    {1'b0, wiper_position_reg} : initial_value_reg;
                `WSLC_ADDR_STORAGE_CONTROL: reg_rdata_out <= storage_control_reg;
                `WSLC_ADDR_WIPER_SOURCE_CONTROL: reg_rdata_out <= wiper_source_control_reg;
                `WSLC_ADDR_TABLE_SLOT_POINTER: reg_rdata_out <= table_slot_pointer_reg;
                `WSLC_ADDR_WIPER_POSITION: reg_rdata_out <= {1'b0, wiper_position_reg};
                `WSLC_ADDR_MANUAL_OVERRIDE_CONTROL: reg_rdata_out <= manual_override_control_reg;
                `WSLC_ADDR_TEMPERATURE_RESULT: reg_rdata_out <= temperature_result_reg;
                `WSLC_ADDR_SUPPLY_VOLTAGE_RESULT: reg_rdata_out <= supply_voltage_result_reg;
                // table addresses and unused offsets read zero
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

endmodule

/* test/wslc_conv_model.sv */
// converter stand-in feeding temperature and supply readings to the block
`timescale 1ns/10ps
module wslc_conv_model (
    // clock and control
    input wire mclk_in,
    input wire enable_in,
    // values the bench wants measured
    input wire [7:0] temp_set_in,
    input wire [7:0] supply_set_in,
    // readings
    output logic [7:0] temp_out = 8'h00,
    output logic [7:0] supply_out = 8'h00
);
    // ----------------------------------------
    // conversion
    // ----------------------------------------
    // stopped converter output
    // a stopped converter gives junk that moves every cycle, so a held result is really held
    always @(posedge mclk_in) begin
        if (enable_in) begin
            temp_out <= temp_set_in;
            supply_out <= supply_set_in;
        end else begin
            temp_out <= ~temp_out;
            supply_out <= supply_out + 8'h35;
        end
    end
endmodule

/* test/wslc_top_assertions.sv */
// port assertions for the wiper source block
`timescale 1ns/10ps
module wslc_top_assertions #(
    parameter int FRAME_CYCLES = 20
) (
    // clock and reset
    input wire mclk_in,
    input wire resetn_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    // converter and wiper
    input wire [7:0] adc_temp_in,
    input wire [7:0] adc_supply_in,
    input wire adc_enable_out,
    input wire frame_tick_out,
    input wire [6:0] wiper_out
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    localparam int GAP = FRAME_CYCLES - 8;
    logic nv_auto = 1'b1;
    logic auto_v, shadow_v, wman_v, seen;
    logic [2:0] ready;
    wire wr_src = reg_wr_in && reg_addr_in == 8'h03;
    wire rdy = ready == 3'h7;
    always @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            auto_v <= nv_auto;
            shadow_v <= 1'b0;
            wman_v <= 1'b0;
            seen <= 1'b0;
            ready <= 3'h0;
        end else begin
            if (!rdy) ready <= ready + 3'h1;
            seen <= seen | frame_tick_out;
            if (wr_src) auto_v <= reg_wdata_in[0];
            if (reg_wr_in && reg_addr_in == 8'h02) shadow_v <= reg_wdata_in[7];
            if (reg_wr_in && reg_addr_in == 8'h0A) wman_v <= reg_wdata_in[2];
        end
    end
    // the nonvolatile copy survives reset, so it has no reset branch
    always @(posedge mclk_in) begin
        if (resetn_in && wr_src && !shadow_v) nv_auto <= reg_wdata_in[0];
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    property p_tick_period;
        frame_tick_out |=> !frame_tick_out [*8] ##GAP frame_tick_out;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("frame tick spacing wrong");
    property p_enable;
        rdy |-> adc_enable_out == auto_v;
    endproperty
    a_enable: assert property (p_enable) else $error("converter enable wrong");
    property p_result_hold;
        (rdy && !frame_tick_out && !$past(frame_tick_out) && !$past(frame_tick_out, 2)
            && $past(reg_addr_in) == 8'h0C && $past(reg_addr_in, 2) == 8'h0C)
            |-> $stable(reg_rdata_out);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved mid frame");
    property p_wiper_walk;
        (rdy && reg_wr_in && reg_addr_in == 8'h09 && wman_v && auto_v)
            |-> ##2 {1'b0, wiper_out} == $past(reg_wdata_in, 2);
    endproperty
    a_wiper_walk: assert property (p_wiper_walk) else $error("manual wiper lost");
    property p_wiper_cause;
        (rdy && $changed(wiper_out)) |-> ($past(frame_tick_out) || $past(frame_tick_out, 2)
            || $past(frame_tick_out, 3) || $past(reg_wr_in, 2) || $past(reg_wr_in, 3));
    endproperty
    a_wiper_cause: assert property (p_wiper_cause) else $error("wiper moved uncaused");
    property p_ptr_first;
        (rdy && !seen && $past(reg_addr_in) == 8'h08) |-> reg_rdata_out == 8'h00;
    endproperty
    a_ptr_first: assert property (p_ptr_first) else $error("pointer not zero");
    property p_ptr_range;
        (rdy && seen && $past(reg_addr_in) == 8'h08) |-> reg_rdata_out inside {[8'h80:8'hC7]};
    endproperty
    a_ptr_range: assert property (p_ptr_range) else $error("pointer off table");
    property p_ovr_bits;
        $past(reg_addr_in) == 8'h0A |-> (reg_rdata_out & 8'hF9) == 8'h00;
    endproperty
    a_ovr_bits: assert property (p_ovr_bits) else $error("override spare bits set");
    property p_src_bits;
        $past(reg_addr_in) == 8'h03 |-> reg_rdata_out[7:2] == 6'h00;
    endproperty
    a_src_bits: assert property (p_src_bits) else $error("source spare bits set");
    c_tick: cover property (frame_tick_out);
    c_manual: cover property (reg_wr_in && reg_addr_in == 8'h09 && wman_v);
    c_auto_off: cover property ($fell(adc_enable_out));
endmodule
bind wslc_top wslc_top_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) chk (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .adc_temp_in(adc_temp_in), .adc_supply_in(adc_supply_in),
    .adc_enable_out(adc_enable_out), .frame_tick_out(frame_tick_out), .wiper_out(wiper_out));

/* test/testbench.sv */
// self-checking bench for the wiper source block
`timescale 1ns/10ps
module testbench;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] temp_set = 8'h00;
    logic [7:0] supply_set = 8'h5A;
    wire [7:0] reg_rdata_out, adc_temp_in, adc_supply_in;
    wire adc_enable_out, frame_tick_out;
    wire [6:0] wiper_out;
    int num_errors = 0;
    int n_tests = 0;
    // readings and expected slots; the hysteresis steps sit in the middle
    logic [7:0] tt [8] = '{8'h00, 8'hD0, 8'hDA, 8'hDC, 8'hDA, 8'hD9, 8'h65, 8'h70};
    logic [7:0] ts [8] = '{8'h94, 8'h80, 8'h81, 8'h82, 8'h82, 8'h81, 8'hC7, 8'hC7};
    // source mode, initial value, table entry, expected wiper
    logic [7:0] cm [5] = '{8'h03, 8'h03, 8'h03, 8'h01, 8'h01};
    logic [7:0] ci [5] = '{8'h10, 8'h01, 8'h50, 8'h10, 8'h10};
    logic [7:0] ce [5] = '{8'h7E, 8'h7C, 8'h3F, 8'h05, 8'hC8};
    logic [7:0] cx [5] = '{8'h0E, 8'h00, 8'h7F, 8'h05, 8'h7F};
    wslc_top #(.FRAME_CYCLES(20), .TABLE_DEPTH(72)) dut (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .adc_temp_in(adc_temp_in), .adc_supply_in(adc_supply_in),
        .adc_enable_out(adc_enable_out), .frame_tick_out(frame_tick_out), .wiper_out(wiper_out));
    wslc_conv_model conv (
        .mclk_in(mclk_in), .enable_in(adc_enable_out), .temp_set_in(temp_set),
        .supply_set_in(supply_set), .temp_out(adc_temp_in), .supply_out(adc_supply_in));
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge mclk_in);
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_in);
        reg_addr_in = a;
        @(negedge mclk_in);
        chk(reg_rdata_out, exp);
    endtask
    task automatic wc(input logic [7:0] exp);
        chk({1'b0, wiper_out}, exp);
    endtask
    // bounded wait for frame ticks; a missing tick ends the run
    task automatic frames(input int n);
        int k;
        for (int f = 0; f < n; f++) begin
            k = 0;
            @(negedge mclk_in);
            while (frame_tick_out !== 1'b1) begin
                k++;
                if (k > 60) begin
                    num_errors++;
                    final_report();
                end
                @(negedge mclk_in);
            end
        end
    endtask
    task automatic do_reset();
        resetn_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge mclk_in);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        do_reset();
        rd(8'h03, 8'h03);
        rd(8'h08, 8'h00);
        rd(8'h0A, 8'h00);
        rd(8'h09, 8'h00);
        wr(8'h0A, 8'hFE);
        rd(8'h0A, 8'h06);
        wr(8'h0A, 8'h00);
        wr(8'h03, 8'hFF);
        rd(8'h03, 8'h03);
        for (int i = 0; i < 8; i++) begin
            temp_set = tt[i];
            supply_set = ~tt[i];
            frames(2);
            rd(8'h08, ts[i]);
            rd(8'h0C, tt[i]);
            rd(8'h0E, ~tt[i]);
        end
        wr(8'h08, 8'h85);
        rd(8'h08, 8'hC7);
        wr(8'h0A, 8'h02);
        wr(8'h08, 8'h85);
        temp_set = 8'h00;
        frames(2);
        rd(8'h08, 8'h85);
        for (int i = 0; i < 5; i++) begin
            wr(8'h03, cm[i]);
            wr(8'h00, ci[i]);
            wr(8'h85, ce[i]);
            frames(3);
            rd(8'h09, cx[i]);
            wc(cx[i]);
        end
        wr(8'h09, 8'h33);
        rd(8'h09, 8'h7F);
        wr(8'h0A, 8'h06);
        wr(8'h09, 8'h33);
        rd(8'h09, 8'h33);
        wc(8'h33);
        wr(8'h0A, 8'h00);
        wr(8'h03, 8'h03);
        wr(8'h02, 8'h80);
        wr(8'h03, 8'h00);
        temp_set = 8'h20;
        frames(2);
        rd(8'h0C, 8'h00);
        rd(8'h0E, 8'h8F);
        wr(8'h00, 8'h22);
        frames(1);
        rd(8'h09, 8'h22);
        wc(8'h22);
        do_reset();
        rd(8'h03, 8'h03);
        wr(8'h00, 8'h2A);
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h80);
        wr(8'h00, 8'h11);
        rd(8'h09, 8'h11);
        rd(8'h00, 8'h11);
        do_reset();
        rd(8'h03, 8'h00);
        rd(8'h00, 8'h2A);
        rd(8'h09, 8'h2A);
        wc(8'h2A);
        final_report();
    end
endmodule
